// ==== ela_capture.sv ====
// Logic analyzer capture core: triggers, trace buffer, readout, stimulus
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Stimulus bus width is a build parameter
// - Stimulus shown once per arm, qualified by valid
// - Pre-store splits depth: 0, 1/4, 1/2, 3/4
// - Marker falls at final trigger sample
// - AND match: all cared channels equal pattern
// - OR match: any cared channel equals pattern
// - AND or OR chosen per trigger stage
// - Sample and trigger on rising user clock
// - Buffer depth fixed; host depth request only sets depth_mismatch
// - Arm clears startup trigger and old trace
module ela_capture
    import ela_pkg::*;
#(
    parameter int STIM_W = 8
)(
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    // Monitored design
    input  wire logic [MON_W-1:0]          mon_data,
    // Control
    input  wire logic                      arm,
    input  wire logic                      startup_en,
    input  wire logic [STAGES*MON_W-1:0]   trig_pat,
    input  wire logic [STAGES*MON_W-1:0]   trig_care,
    input  wire logic [STAGES-1:0]         trig_or,
    input  wire logic [SW-1:0]             trig_stages,
    input  wire logic [1:0]                pre_sel,
    input  wire logic [CW-1:0]             depth_req,
    // Stimulus
    input  wire logic [STIM_W-1:0]         stim_in,
    output logic      [STIM_W-1:0]         stim_out,
    output logic                           stim_valid,
    // Trace readout
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output logic      [REC_W-1:0]          out_data,
    // Status
    output logic                           busy,
    output logic                           triggered,
    output logic                           done,
    output logic                           depth_mismatch
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_s1_reg, rst_s2_reg, rst_n;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    assign rst_n = rst_s2_reg;

    // ************************************************************
    // Trigger matching
    // ************************************************************
    logic [STAGES-1:0] hit_vec;
    logic [SW-1:0]     last_stage;
    logic              cur_hit, final_hit;

    ela_state_t        state_reg, state_next;
    logic [SW-1:0]     stage_reg, stage_next;

    genvar g;
    generate
        for (g = 0; g < STAGES; g++)
        begin : g_stage
            // Per-stage combining mode
            assign hit_vec[g] = ela_match(mon_data,
                                          trig_pat[g*MON_W +: MON_W],
                                          trig_care[g*MON_W +: MON_W],
                                          trig_or[g]);
        end
    endgenerate

    assign last_stage = (trig_stages == STAGE_0) ? STAGE_0
                                                 : trig_stages - STAGE_ONE;
    assign cur_hit    = hit_vec[stage_reg];
    assign final_hit  = (state_reg == ST_CAPT) && cur_hit &&
                        (stage_reg == last_stage);

    // ************************************************************
    // Capture and readout control
    // ************************************************************
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0]    fill_reg, fill_next, post_reg, post_next;
    logic [CW-1:0]    left_reg, left_next;
    logic [CW-1:0]    pre_len, pre_avail, post_len;
    logic             pend_reg, pend_next, trig_reg, trig_next;
    logic             boot_reg, boot_next, spend_reg, spend_next;
    logic             start_go, issue, wr_en, mark, fifo_in_ready;
    logic [REC_W-1:0] mem_rd_data;

    assign pre_len   = ela_pre_len(pre_sel);
    assign pre_avail = (fill_reg < pre_len) ? fill_reg : pre_len;
    assign post_len  = DEPTH_C - pre_len;
    assign start_go  = arm || (spend_reg && state_reg == ST_IDLE);
    assign issue     = (state_reg == ST_READ) && (left_reg != ZERO_C) &&
                       (!pend_reg || fifo_in_ready);
    assign wr_en     = ((state_reg == ST_CAPT) ||
                        (state_reg == ST_POST)) && !start_go;
    assign mark      = (pre_sel != PRE_0) && (state_reg == ST_CAPT) &&
                       !final_hit;

    always_comb
    begin
        state_next  = state_reg;
        stage_next  = stage_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        fill_next   = fill_reg;
        post_next   = post_reg;
        left_next   = left_reg;
        trig_next   = trig_reg;
        boot_next   = 1'b1;
        spend_next  = boot_reg ? spend_reg : startup_en;
        pend_next   = issue || (pend_reg && !fifo_in_ready);
        if (start_go)
        begin
            // New session drops pending startup and old trace
            state_next  = ST_CAPT;
            stage_next  = STAGE_0;
            wr_ptr_next = '0;
            fill_next   = ZERO_C;
            trig_next   = 1'b0;
            spend_next  = 1'b0;
            pend_next   = 1'b0;
            left_next   = ZERO_C;
        end
        else
        begin
            case (state_reg)
                ST_CAPT:
                begin
                    wr_ptr_next = wr_ptr_reg + PTR_ONE;
                    fill_next   = (fill_reg == DEPTH_C) ? fill_reg
                                                        : fill_reg + ONE_C;
                    if (final_hit)
                    begin
                        state_next  = ST_POST;
                        post_next   = post_len - ONE_C;
                        rd_ptr_next = wr_ptr_reg - pre_avail[AW-1:0];
                        left_next   = pre_avail + post_len;
                        trig_next   = 1'b1;
                    end
                    else if (cur_hit)
                        stage_next = stage_reg + STAGE_ONE;
                end
                ST_POST:
                begin
                    wr_ptr_next = wr_ptr_reg + PTR_ONE;
                    post_next   = post_reg - ONE_C;
                    if (post_reg == ONE_C)
                        state_next = ST_READ;
                end
                ST_READ:
                begin
                    if (issue)
                    begin
                        rd_ptr_next = rd_ptr_reg + PTR_ONE;
                        left_next   = left_reg - ONE_C;
                    end
                    if (left_reg == ZERO_C && !pend_reg)
                        state_next = ST_DONE;
                end
                ST_IDLE, ST_DONE:
                begin
                    state_next = state_reg;
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg  <= ST_IDLE;
            stage_reg  <= STAGE_0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= ZERO_C;
            post_reg   <= ZERO_C;
            left_reg   <= ZERO_C;
            trig_reg   <= 1'b0;
            boot_reg   <= 1'b0;
            spend_reg  <= 1'b0;
            pend_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            stage_reg  <= stage_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            fill_reg   <= fill_next;
            post_reg   <= post_next;
            left_reg   <= left_next;
            trig_reg   <= trig_next;
            boot_reg   <= boot_next;
            spend_reg  <= spend_next;
            pend_reg   <= pend_next;
        end
    end

    // ************************************************************
    // Trace memory and readout FIFO
    // ************************************************************
    ela_trace_mem #(
        .W       (REC_W),
        .D       (DEPTH),
        .A       (AW)
    ) u_mem (
        .clk     (core_clk),
        .wr_en   (wr_en),
        .wr_addr (wr_ptr_reg),
        .wr_data ({mark, mon_data}),
        .rd_en   (issue),
        .rd_addr (rd_ptr_reg),
        .rd_data (mem_rd_data)
    );

    ela_fifo #(
        .W         (REC_W),
        .D         (FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .flush     (start_go),
        .in_valid  (pend_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rd_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // ************************************************************
    // Stimulus and status
    // ************************************************************
    logic [STIM_W-1:0] stim_reg, stim_next;
    logic              svld_reg, svld_next, dmis_reg, dmis_next;

    always_comb
    begin
        stim_next = arm ? stim_in : stim_reg;
        svld_next = arm;
        dmis_next = (depth_req != DEPTH_C);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stim_reg <= '0;
            svld_reg <= 1'b0;
            dmis_reg <= 1'b0;
        end
        else
        begin
            stim_reg <= stim_next;
            svld_reg <= svld_next;
            dmis_reg <= dmis_next;
        end
    end

    assign stim_out       = stim_reg;
    assign stim_valid     = svld_reg;
    assign depth_mismatch = dmis_reg;
    assign busy           = (state_reg == ST_CAPT) || (state_reg == ST_POST);
    assign triggered      = trig_reg;
    assign done           = (state_reg == ST_DONE);

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_armed;
        arm;
    endsequence
    sequence s_cleared;
        state_reg == ST_CAPT && stage_reg == STAGE_0 && fill_reg == ZERO_C;
    endsequence

    property p_stim_once;
        s_armed ##1 !arm |=> !stim_valid;
    endproperty
    a_stim_once: assert property (p_stim_once)
        else $error("stimulus valid held too long");

    property p_stim_word;
        s_armed |=> stim_valid && stim_out == $past(stim_in);
    endproperty
    a_stim_word: assert property (p_stim_word)
        else $error("stimulus word not taken at arm");

    property p_arm_clear;
        s_armed |=> s_cleared ##0 !triggered;
    endproperty
    a_arm_clear: assert property (p_arm_clear)
        else $error("arm did not clear capture state");

    property p_post_len;
        final_hit && !arm |=> state_reg == ST_POST &&
            post_reg == DEPTH_C - ela_pre_len(pre_sel) - ONE_C;
    endproperty
    a_post_len: assert property (p_post_len)
        else $error("post trigger count wrong");

    property p_mark_fall;
        wr_en && pre_sel != PRE_0 && $past(state_reg) == ST_CAPT &&
            state_reg == ST_CAPT ##1 final_hit |-> !mark ##0 $past(mark);
    endproperty
    a_mark_fall: assert property (p_mark_fall)
        else $error("pre-store marker did not fall at trigger");

    property p_and_miss;
        state_reg == ST_CAPT && !trig_or[0] &&
            ((mon_data ^ trig_pat[MON_W-1:0]) & trig_care[MON_W-1:0]) != '0
            |-> !hit_vec[0];
    endproperty
    a_and_miss: assert property (p_and_miss)
        else $error("AND stage matched on a differing channel");

    property p_or_hit;
        !trig_or[1] || ((~(mon_data ^ trig_pat[2*MON_W-1:MON_W])) &
            trig_care[2*MON_W-1:MON_W]) == '0 || hit_vec[1];
    endproperty
    a_or_hit: assert property (p_or_hit)
        else $error("OR stage missed an equal channel");

    property p_stage_order;
        !arm && state_reg == ST_CAPT && !cur_hit |=> $stable(stage_reg);
    endproperty
    a_stage_order: assert property (p_stage_order)
        else $error("stage advanced without a match");

    property p_depth_flag;
        depth_req != DEPTH_C |=> depth_mismatch;
    endproperty
    a_depth_flag: assert property (p_depth_flag)
        else $error("depth mismatch not flagged");
endmodule // ela_capture
`default_nettype wire

// ==== ela_dut_model.sv ====
// Behavioural model of the monitored user design
`timescale 1ns/1ps
`default_nettype none
module ela_dut_model
    import ela_pkg::*;
#(
    parameter int STIM_W = 8
)(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Stimulus from the analyzer
    input  wire logic [STIM_W-1:0] stim_out,
    input  wire logic              stim_valid,
    // Observed design state
    output logic      [MON_W-1:0]  mon_data,
    output logic      [STIM_W-1:0] stim_seen,
    output logic      [7:0]        stim_count
);
    // ************************************************************
    // Counter under observation, stimulus taken only when valid
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mon_data   <= '0;
            stim_seen  <= '0;
            stim_count <= 8'h00;
        end
        else
        begin
            mon_data <= mon_data + 32'h1;
            if (stim_valid)
            begin
                stim_seen  <= stim_out;
                stim_count <= stim_count + 8'h01;
            end
        end
    end
endmodule // ela_dut_model
`default_nettype wire

// ==== ela_fifo.sv ====
// Readout FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ela_fifo
    import ela_pkg::*;
#(
    parameter int W = REC_W,
    parameter int D = FIFO_DEPTH
)(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int PA = $clog2(D);
    localparam logic [PA:0]   CNT_FULL = (PA+1)'(D);
    localparam logic [PA:0]   CNT_ONE  = (PA+1)'(1);
    localparam logic [PA-1:0] P_ONE    = PA'(1);

    logic [W-1:0]  mem [0:D-1];
    logic [PA-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [PA:0]   cnt_reg, cnt_next;
    logic          push, pop;

    assign in_ready  = (cnt_reg != CNT_FULL);
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rp_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wp_next  = push ? wp_reg + P_ONE : wp_reg;
        rp_next  = pop ? rp_reg + P_ONE : rp_reg;
        cnt_next = cnt_reg;
        if (push && !pop)
            cnt_next = cnt_reg + CNT_ONE;
        else if (pop && !push)
            cnt_next = cnt_reg - CNT_ONE;
        if (flush)
        begin
            wp_next  = '0;
            rp_next  = '0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push && !flush)
            mem[wp_reg] <= in_data;
    end
endmodule // ela_fifo
`default_nettype wire

// ==== ela_pkg.sv ====
// Shared constants, types and functions of the logic analyzer capture block
`default_nettype none
package ela_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int MON_W      = 32;
    localparam int STAGES     = 3;
    localparam int DEPTH      = 1024;
    localparam int AW         = 10;
    localparam int CW         = AW + 1;
    localparam int SW         = 2;
    localparam int FIFO_DEPTH = 32;
    localparam int STIM_MAX   = 512;
    localparam int REC_W      = MON_W + 1;

    // ************************************************************
    // Counts and encodings
    // ************************************************************
    localparam logic [CW-1:0] DEPTH_C   = 11'h400;
    localparam logic [CW-1:0] QUARTER_C = 11'h100;
    localparam logic [CW-1:0] ONE_C     = 11'h001;
    localparam logic [CW-1:0] ZERO_C    = 11'h000;
    localparam logic [AW-1:0] PTR_ONE   = 10'h001;
    localparam logic [SW-1:0] STAGE_ONE = 2'h1;
    localparam logic [SW-1:0] STAGE_0   = 2'h0;
    localparam logic [1:0]    PRE_0     = 2'h0;
    localparam logic [1:0]    PRE_25    = 2'h1;
    localparam logic [1:0]    PRE_50    = 2'h2;
    localparam logic [1:0]    PRE_75    = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CAPT = 3'b001,
        ST_POST = 3'b010,
        ST_READ = 3'b011,
        ST_DONE = 3'b100
    } ela_state_t;

    // ************************************************************
    // Functions
    // ************************************************************
    // Pattern match of one stage; care bit high means compared
    function automatic logic ela_match(input logic [MON_W-1:0] mon,
                                       input logic [MON_W-1:0] pat,
                                       input logic [MON_W-1:0] care,
                                       input logic             or_mode);
        logic [MON_W-1:0] eq;
        eq = ~(mon ^ pat);
        if (or_mode)
            ela_match = |(eq & care);
        else
            ela_match = &(eq | ~care);
    endfunction

    // Samples kept ahead of the trigger for a pre-store setting
    function automatic logic [CW-1:0] ela_pre_len(input logic [1:0] sel);
        case (sel)
            PRE_25:  ela_pre_len = QUARTER_C;
            PRE_50:  ela_pre_len = QUARTER_C + QUARTER_C;
            PRE_75:  ela_pre_len = QUARTER_C + QUARTER_C + QUARTER_C;
            default: ela_pre_len = ZERO_C;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== ela_trace_mem.sv ====
// Trace sample memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ela_trace_mem
    import ela_pkg::*;
#(
    parameter int W = REC_W,
    parameter int D = DEPTH,
    parameter int A = AW
)(
    // Clock
    input  wire logic         clk,
    // Write port
    input  wire logic         wr_en,
    input  wire logic [A-1:0] wr_addr,
    input  wire logic [W-1:0] wr_data,
    // Read port
    input  wire logic         rd_en,
    input  wire logic [A-1:0] rd_addr,
    output logic      [W-1:0] rd_data
);
    logic [W-1:0] mem [0:D-1];
    logic [W-1:0] rd_data_reg;

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        if (rd_en)
            rd_data_reg <= mem[rd_addr];
    end

    assign rd_data = rd_data_reg;
endmodule // ela_trace_mem
`default_nettype wire

// ==== tb_embedded_logic_analyzer_capture.sv ====
// Self-checking bench of the logic analyzer capture core
`timescale 1ns/1ps
`default_nettype none
module tb_embedded_logic_analyzer_capture;
    import ela_pkg::*;
    localparam int SWID = 8;
    logic                    core_clk, rst_b, arm, startup_en, out_ready;
    logic [STAGES*MON_W-1:0] trig_pat, trig_care;
    logic [STAGES-1:0]       trig_or;
    logic [SW-1:0]           trig_stages;
    logic [1:0]              pre_sel;
    logic [CW-1:0]           depth_req;
    logic [SWID-1:0]         stim_in, stim_out, stim_seen;
    logic [MON_W-1:0]        mon_data, base, trig_t;
    logic [REC_W-1:0]        out_data;
    logic [7:0]              stim_count, scount;
    logic                    stim_valid, out_valid, busy, triggered;
    logic                    done, depth_mismatch;
    int                      mismatches, samples_checked;
    int                      cycles = 0;

    ela_capture #(.STIM_W(SWID)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .mon_data(mon_data),
        .arm(arm), .startup_en(startup_en), .trig_pat(trig_pat),
        .trig_care(trig_care), .trig_or(trig_or),
        .trig_stages(trig_stages), .pre_sel(pre_sel),
        .depth_req(depth_req), .stim_in(stim_in), .stim_out(stim_out),
        .stim_valid(stim_valid), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .busy(busy),
        .triggered(triggered), .done(done),
        .depth_mismatch(depth_mismatch));

    ela_dut_model #(.STIM_W(SWID)) far (
        .core_clk(core_clk), .rst_b(rst_b), .stim_out(stim_out),
        .stim_valid(stim_valid), .mon_data(mon_data),
        .stim_seen(stim_seen), .stim_count(stim_count));

    // ************************************************************
    // Clock, timeout and checking helpers
    // ************************************************************
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [REC_W-1:0] exp,
                       input logic [REC_W-1:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Word idx of the trace: pre samples marked, then trigger onwards
    function automatic logic [REC_W-1:0] exp_word(input int idx,
        input logic [1:0] pre, input logic [MON_W-1:0] t);
        int plen;
        plen = int'(pre) * int'(QUARTER_C);
        exp_word = {(pre != PRE_0) && (idx < plen),
                    t - MON_W'(plen) + MON_W'(idx)};
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Arm with a fresh stimulus; trigger lands at mon value base+off
    task automatic arm_once(input logic [MON_W-1:0] off);
        @(negedge core_clk);
        stim_in = SWID'($urandom);
        base = mon_data;
        trig_t = base + off;
        trig_pat = {trig_t, (trig_t - 32'h1) ^ 32'h2, trig_t - 32'h2};
        scount = stim_count;
        arm = 1'b1;
        @(negedge core_clk);
        arm = 1'b0;
        chk("stim_valid", 1'b1, stim_valid);
        chk("stim_out", stim_in, stim_out);
        chk("busy", 1'b1, busy);
        chk("done", 1'b0, done);
        chk("triggered", 1'b0, triggered);
        chk("out_valid", 1'b0, out_valid);
        @(negedge core_clk);
        chk("stim_valid", 1'b0, stim_valid);
        chk("stim_count", scount + 8'h01, stim_count);
        chk("stim_seen", stim_in, stim_seen);
    endtask

    // Drain; the 60-cycle stalled start ends in post-store, before readout begins
    task automatic drain(input logic [1:0] pre);
        int n;
        int k;
        n = 0;
        k = 0;
        while (!(done === 1'b1 && out_valid === 1'b0))
        begin
            @(negedge core_clk);
            k++;
            // Word shown now is popped at the next rising edge
            out_ready = (k > 60) && ($urandom_range(3, 0) != 0);
            if (out_valid === 1'b1 && out_ready === 1'b1)
            begin
                chk("word", exp_word(n, pre, trig_t), out_data);
                n++;
            end
        end
        chk("count", DEPTH, n);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        arm = 1'b0;
        startup_en = 1'b1;
        trig_pat = '1;
        trig_care = '1;
        trig_or = 3'h2;
        trig_stages = 2'h3;
        pre_sel = PRE_0;
        depth_req = DEPTH_C;
        stim_in = '0;
        out_ready = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        void'($urandom(32'h4d54));
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (8) @(negedge core_clk);
        chk("busy", 1'b1, busy);
        chk("stim_valid", 1'b0, stim_valid);
        trig_care = {32'h000000ff, 32'h00000003, 32'hffffffff};
        for (int p = 0; p < 4; p++)
        begin
            pre_sel = 2'(p);
            depth_req = p[0] ? 11'($urandom_range(2047, 1025)) : DEPTH_C;
            arm_once(32'd2000);
            repeat ($urandom_range(20, 3)) @(negedge core_clk);
            arm_once(32'd1000 + 32'($urandom_range(200, 0)));
            chk("depth_mismatch", p[0], depth_mismatch);
            while (mon_data !== trig_t)
                @(negedge core_clk);
            chk("triggered", 1'b0, triggered);
            repeat (2) @(negedge core_clk);
            chk("triggered", 1'b1, triggered);
            drain(pre_sel);
        end
        final_report();
    end
endmodule // tb_embedded_logic_analyzer_capture
`default_nettype wire
